// >>> pkg/motion_defines.svh
/*
 * Object indexes, reset values and timing figures for the motion
 * target window monitor.
 * Assumes the object access port presents a 16-bit dictionary index.
 */
`ifndef MOTION_DEFINES_SVH
`define MOTION_DEFINES_SVH

// Dictionary indexes
`define IDX_OP_MODE 16'h6060
`define IDX_POS_WINDOW 16'h6067
`define IDX_POS_SETTLE_TIME 16'h6068
`define IDX_SPEED_SETPOINT_OUT 16'h606b
`define IDX_SPEED_MEASURED 16'h606c
`define IDX_SPEED_REACHED_BAND 16'h606d
`define IDX_SPEED_SETTLE_TIME 16'h606e
`define IDX_NONZERO_SPEED_LEVEL 16'h606f
`define IDX_NONZERO_SPEED_TIME 16'h6070
`define IDX_TORQUE_SETPOINT_IN 16'h6071
`define IDX_TORQUE_MAX 16'h6072
`define IDX_CURRENT_MAX 16'h6073

// Reset values
`define RST_OP_MODE 8'h00
`define RST_POS_WINDOW 32'h0000000a
`define RST_POS_SETTLE_TIME 16'h0064
`define RST_SPEED_REACHED_BAND 16'h001e
`define RST_SPEED_SETTLE_TIME 16'h0000
`define RST_NONZERO_SPEED_LEVEL 16'h0000
`define RST_NONZERO_SPEED_TIME 16'h0000
`define RST_TORQUE_SETPOINT_IN 16'h0000
`define RST_TORQUE_MAX 16'h0064
`define RST_CURRENT_MAX 16'h03e8

// Window values that switch position monitoring off
`define POS_WINDOW_OFF 32'h0fffffff
`define POS_WINDOW_ALL_ONES 32'hffffffff

// Time base
`define CLK_PERIOD_NS 4
`define TICK_TIME_NS 1000000

`endif

// >>> pkg/motion_pkg.sv
/*
 * Types shared by the motion target window monitor.
 * Assumes mode codes arrive as signed 8-bit selectors.
 */
package motion_pkg;

    // Operating mode codes the monitor reacts to
    typedef enum logic [7:0] {
        MODE_PROFILE_POS = 8'h01,
        MODE_PROFILE_VEL = 8'h03,
        MODE_PROFILE_TRQ = 8'h04,
        MODE_INTERP_POS = 8'h07,
        MODE_CYCLIC_TRQ = 8'h0a
    } op_mode_t;

    // Persistence channels
    typedef enum int {
        CH_POS = 0,
        CH_VEL = 1,
        CH_NZ = 2
    } settle_ch_t;

endpackage

// >>> rtl/settle_timer.sv
/*
 * Persistence timer: counts millisecond ticks while a condition holds.
 * Assumes tick_i is a one-cycle pulse on the same clock.
 */
module settle_timer (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Condition and time base
    input wire logic cond_i,
    input wire logic tick_i,
    input wire logic [15:0] limit_i,
    input wire logic strict_i,
    // Result
    output logic held_o
);

    logic [15:0] count;
    wire at_top = count == 16'hffff;

    // Restart whenever the condition drops; saturate rather than wrap
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= 16'h0000;
        end else if (!cond_i) begin
            count <= 16'h0000;
        end else if (tick_i && !at_top) begin
            count <= count + 16'h0001;
        end
    end

    // Strict means longer than the limit, else at least the limit
    assign held_o = cond_i && (strict_i ? (count > limit_i)
                                        : (count >= limit_i));

endmodule

// >>> rtl/motion_target_window_monitor.sv
/*
 * Motion target window monitor: target-reached and nonzero-speed status,
 * dictionary objects for windows and times, and the limited torque set
 * value.
 * Assumes feedback inputs come from logic on sys_clk_i and the object
 * port is driven by a fieldbus stack on the same clock.
 */
`include "motion_defines.svh"

module motion_target_window_monitor #(
    parameter int unsigned TICK_CYCLES = `TICK_TIME_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Object access port
    input wire logic [15:0] obj_index_i,
    input wire logic obj_wr_i,
    input wire logic obj_rd_i,
    input wire logic [31:0] obj_wdata_i,
    output logic [31:0] obj_rdata_o,
    output logic obj_ack_o,
    output logic obj_err_o,
    // Motion feedback
    input wire logic signed [31:0] pos_actual_i,
    input wire logic signed [31:0] pos_target_i,
    input wire logic signed [31:0] speed_target_i,
    input wire logic signed [31:0] ramp_speed_i,
    input wire logic signed [31:0] speed_actual_i,
    // Status and set values
    output logic target_reached_o,
    output logic speed_zero_o,
    output logic signed [31:0] vel_ctrl_setpoint_o,
    output logic signed [15:0] torque_cmd_o,
    output logic torque_active_o
);

    // Parameter objects
    logic [7:0] op_mode;
    logic [31:0] pos_window;
    logic [15:0] pos_settle_time_ms;
    logic [15:0] speed_reached_band;
    logic [15:0] speed_settle_time_ms;
    logic [15:0] nonzero_speed_level;
    logic [15:0] nonzero_speed_time_ms;
    logic [15:0] torque_setpoint_in;
    logic [15:0] torque_max;
    logic [15:0] current_max;

    // Millisecond tick
    logic [17:0] tick_count;
    logic tick;
    wire tick_wrap = tick_count == 18'(TICK_CYCLES - 1);

    // One pulse per millisecond for all persistence counters
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_count <= 18'h00000;
            tick <= 1'b0;
        end else begin
            tick_count <= tick_wrap ? 18'h00000 : tick_count + 18'h00001;
            tick <= tick_wrap;
        end
    end

    // Mode decode
    wire pos_mode = op_mode == motion_pkg::MODE_PROFILE_POS ||
                    op_mode == motion_pkg::MODE_INTERP_POS;
    wire vel_mode = op_mode == motion_pkg::MODE_PROFILE_VEL;
    wire torque_mode = op_mode == motion_pkg::MODE_PROFILE_TRQ ||
                       op_mode == motion_pkg::MODE_CYCLIC_TRQ;

    // Position error magnitude, one bit wider to survive overflow
    wire signed [32:0] pos_diff = {pos_actual_i[31], pos_actual_i} -
                                  {pos_target_i[31], pos_target_i};
    wire [32:0] pos_err = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
    wire pos_in_window = pos_err < {1'b0, pos_window};
    wire pos_monitor_off = pos_window == `POS_WINDOW_OFF ||
                           pos_window == `POS_WINDOW_ALL_ONES;

    // Speed error magnitude against the symmetric band
    wire signed [32:0] spd_diff = {speed_actual_i[31], speed_actual_i} -
                                  {speed_target_i[31], speed_target_i};
    wire [32:0] spd_err = spd_diff[32] ? 33'(-spd_diff) : 33'(spd_diff);
    wire spd_in_band = spd_err < {17'h00000, speed_reached_band};

    // Speed magnitude against the nonzero level
    wire [32:0] spd_mag = speed_actual_i[31] ?
                          33'(-{speed_actual_i[31], speed_actual_i}) :
                          {1'b0, speed_actual_i};
    wire spd_above = spd_mag > {17'h00000, nonzero_speed_level};

    // Persistence channels share one timer design
    logic [2:0] ch_cond;
    logic [2:0] ch_strict;
    logic [2:0] ch_held;
    logic [15:0] ch_limit [3];
    assign ch_cond[motion_pkg::CH_POS] = pos_mode && pos_in_window &&
                                         !pos_monitor_off;
    assign ch_cond[motion_pkg::CH_VEL] = vel_mode && spd_in_band;
    assign ch_cond[motion_pkg::CH_NZ] = vel_mode && spd_above;
    assign ch_limit[motion_pkg::CH_POS] = pos_settle_time_ms;
    assign ch_limit[motion_pkg::CH_VEL] = speed_settle_time_ms;
    assign ch_limit[motion_pkg::CH_NZ] = nonzero_speed_time_ms;
    // Windows need longer than their time, the level at least its time
    assign ch_strict = 3'h3;

    for (genvar g = 0; g < 3; g++) begin : g_settle
        settle_timer u_timer (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .cond_i(ch_cond[g]),
            .tick_i(tick),
            .limit_i(ch_limit[g]),
            .strict_i(ch_strict[g]),
            .held_o(ch_held[g])
        );
    end

    // Status bits
    wire next_target_reached = ch_held[motion_pkg::CH_POS] ||
                               ch_held[motion_pkg::CH_VEL];
    wire next_speed_zero = !ch_held[motion_pkg::CH_NZ];

    // Torque limit: smaller of the two maxima, both in tenths of percent
    wire [15:0] torque_limit = (torque_max < current_max) ?
                               torque_max : current_max;
    wire signed [16:0] trq_req = {torque_setpoint_in[15],
                                  torque_setpoint_in};
    wire signed [16:0] trq_hi = {1'b0, torque_limit};
    wire signed [16:0] trq_lo = 17'(-trq_hi);
    wire signed [16:0] trq_clamped = (trq_req > trq_hi) ? trq_hi :
                                     (trq_req < trq_lo) ? trq_lo : trq_req;
    // A limit above 32767 still leaves the request inside 16 bits
    wire [15:0] next_torque_cmd = torque_mode ?
                                  trq_clamped[15:0] : 16'h0000;

    // Registered status and set values
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            target_reached_o <= 1'b0;
            speed_zero_o <= 1'b1;
            vel_ctrl_setpoint_o <= 32'h00000000;
            torque_cmd_o <= 16'h0000;
            torque_active_o <= 1'b0;
        end else begin
            target_reached_o <= next_target_reached;
            speed_zero_o <= next_speed_zero;
            vel_ctrl_setpoint_o <= ramp_speed_i;
            torque_cmd_o <= next_torque_cmd;
            torque_active_o <= torque_mode;
        end
    end

    // Object decode
    wire hit_mode = obj_index_i == `IDX_OP_MODE;
    wire hit_pwin = obj_index_i == `IDX_POS_WINDOW;
    wire hit_ptime = obj_index_i == `IDX_POS_SETTLE_TIME;
    wire hit_vdem = obj_index_i == `IDX_SPEED_SETPOINT_OUT;
    wire hit_vact = obj_index_i == `IDX_SPEED_MEASURED;
    wire hit_vband = obj_index_i == `IDX_SPEED_REACHED_BAND;
    wire hit_vtime = obj_index_i == `IDX_SPEED_SETTLE_TIME;
    wire hit_nzlvl = obj_index_i == `IDX_NONZERO_SPEED_LEVEL;
    wire hit_nztime = obj_index_i == `IDX_NONZERO_SPEED_TIME;
    wire hit_trq = obj_index_i == `IDX_TORQUE_SETPOINT_IN;
    wire hit_tmax = obj_index_i == `IDX_TORQUE_MAX;
    wire hit_cmax = obj_index_i == `IDX_CURRENT_MAX;
    wire hit_ro = hit_vdem || hit_vact;
    wire hit_rw = hit_mode || hit_pwin || hit_ptime || hit_vband ||
                  hit_vtime || hit_nzlvl || hit_nztime || hit_trq ||
                  hit_tmax || hit_cmax;
    wire obj_access = obj_wr_i || obj_rd_i;
    wire wr_ok = obj_wr_i && hit_rw;
    wire next_err = (obj_access && !(hit_rw || hit_ro)) ||
                    (obj_wr_i && hit_ro);

    // Parameter writes; read-only objects never take data
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_mode <= `RST_OP_MODE;
            pos_window <= `RST_POS_WINDOW;
            pos_settle_time_ms <= `RST_POS_SETTLE_TIME;
            speed_reached_band <= `RST_SPEED_REACHED_BAND;
            speed_settle_time_ms <= `RST_SPEED_SETTLE_TIME;
            nonzero_speed_level <= `RST_NONZERO_SPEED_LEVEL;
            nonzero_speed_time_ms <= `RST_NONZERO_SPEED_TIME;
            torque_setpoint_in <= `RST_TORQUE_SETPOINT_IN;
            torque_max <= `RST_TORQUE_MAX;
            current_max <= `RST_CURRENT_MAX;
        end else if (wr_ok) begin
            if (hit_mode) op_mode <= obj_wdata_i[7:0];
            if (hit_pwin) pos_window <= obj_wdata_i;
            if (hit_ptime) pos_settle_time_ms <= obj_wdata_i[15:0];
            if (hit_vband) speed_reached_band <= obj_wdata_i[15:0];
            if (hit_vtime) speed_settle_time_ms <= obj_wdata_i[15:0];
            if (hit_nzlvl) nonzero_speed_level <= obj_wdata_i[15:0];
            if (hit_nztime) nonzero_speed_time_ms <= obj_wdata_i[15:0];
            if (hit_trq) torque_setpoint_in <= obj_wdata_i[15:0];
            if (hit_tmax) torque_max <= obj_wdata_i[15:0];
            if (hit_cmax) current_max <= obj_wdata_i[15:0];
        end
    end

    // Read selection; signed objects are sign extended
    wire [31:0] next_rdata =
        hit_mode ? {{24{op_mode[7]}}, op_mode} :
        hit_pwin ? pos_window :
        hit_ptime ? {16'h0000, pos_settle_time_ms} :
        hit_vdem ? ramp_speed_i :
        hit_vact ? speed_actual_i :
        hit_vband ? {16'h0000, speed_reached_band} :
        hit_vtime ? {16'h0000, speed_settle_time_ms} :
        hit_nzlvl ? {16'h0000, nonzero_speed_level} :
        hit_nztime ? {16'h0000, nonzero_speed_time_ms} :
        hit_trq ? {{16{torque_setpoint_in[15]}}, torque_setpoint_in} :
        hit_tmax ? {16'h0000, torque_max} :
        hit_cmax ? {16'h0000, current_max} : 32'h00000000;

    // Every access is answered one cycle later
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            obj_rdata_o <= 32'h00000000;
            obj_ack_o <= 1'b0;
            obj_err_o <= 1'b0;
        end else begin
            obj_rdata_o <= obj_rd_i ? next_rdata : 32'h00000000;
            obj_ack_o <= obj_access;
            obj_err_o <= next_err;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    wire [16:0] torque_mag = torque_cmd_o[15] ?
                             17'(-{torque_cmd_o[15], torque_cmd_o}) :
                             {1'b0, torque_cmd_o};

    sequence s_ro_write;
        obj_wr_i && hit_ro;
    endsequence

    sequence s_refused;
        obj_ack_o && obj_err_o;
    endsequence

    a_reach_needs_mode: assert property (
        target_reached_o |-> $past(pos_mode || vel_mode))
        else $error("target reached outside a monitored mode");
    a_pos_off_blocks: assert property (
        (pos_mode && pos_monitor_off) |=> !target_reached_o)
        else $error("position monitoring not switched off");
    a_pos_window_miss: assert property (
        (pos_mode && !pos_in_window) |=> !target_reached_o)
        else $error("target reached with position outside window");
    a_zero_default: assert property (
        !vel_mode |=> speed_zero_o)
        else $error("nonzero speed flagged outside velocity mode");
    a_torque_limit: assert property (
        torque_active_o |-> torque_mag <= {1'b0, $past(torque_limit)})
        else $error("torque command above limit");
    a_torque_mode: assert property (
        !torque_mode |=> (torque_cmd_o == 16'h0000) && !torque_active_o)
        else $error("torque command outside torque modes");
    a_ramp_copy: assert property (
        ##1 vel_ctrl_setpoint_o == $past(ramp_speed_i))
        else $error("velocity setpoint differs from ramp output");
    a_ro_refused: assert property (
        s_ro_write |=> s_refused)
        else $error("write to read-only object not refused");
    a_ack_follows: assert property (
        obj_access |=> obj_ack_o ##1 (obj_ack_o == $past(obj_access)))
        else $error("object access not acknowledged");
    a_tick_single: assert property (
        tick |=> !tick)
        else $error("millisecond tick longer than one cycle");
    a_band_miss: assert property (
        (vel_mode && !spd_in_band) |=> !target_reached_o)
        else $error("target reached with speed outside band");
    a_nz_needs_speed: assert property (
        !speed_zero_o |-> $past(vel_mode && spd_above))
        else $error("nonzero speed flagged below level");
    a_trq_pass: assert property (
        (torque_mode && trq_req <= trq_hi && trq_req >= trq_lo) |=>
            torque_cmd_o == $past(trq_req[15:0]))
        else $error("torque request inside limit was altered");
    a_rdata_idle: assert property (
        !obj_rd_i |=> obj_rdata_o == 32'h00000000)
        else $error("read data shown without a read");

endmodule

// >>> bench/obj_master.sv
/*
 * Fieldbus master model: single-object write and read accesses.
 * Assumes the monitor acks one cycle after each one-cycle strobe.
 */
module obj_master #(
    parameter int PEAK_TORQUE = 3000
) (
    // Clock
    input wire logic sys_clk_i,
    // Object access port
    output logic [15:0] obj_index_o,
    output logic obj_wr_o,
    output logic obj_rd_o,
    output logic [31:0] obj_wdata_o,
    input wire logic [31:0] obj_rdata_i,
    input wire logic obj_ack_i,
    input wire logic obj_err_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle port at time zero
    initial begin
        obj_index_o = 16'h0000;
        obj_wr_o = 1'b0;
        obj_rd_o = 1'b0;
        obj_wdata_o = 32'h00000000;
    end

    // Mode selector word, only documented codes can be passed
    function automatic logic [31:0] mode_word(input motion_pkg::op_mode_t m);
        return {24'h000000, m};
    endfunction

    // Never ask for more than the peak torque
    function automatic logic [31:0] torque_word(input int t);
        int c;
        c = (t > PEAK_TORQUE) ? PEAK_TORQUE : t;
        c = (c < -PEAK_TORQUE) ? -PEAK_TORQUE : c;
        return 32'(c);
    endfunction

    // One access; index and data held to the ack edge, then scrambled
    task automatic access(input logic wr, input logic [15:0] idx,
            input logic [31:0] wd, output logic [31:0] rd,
            output logic er, output logic ok);
        ok = 1'b0;
        rd = 32'h00000000;
        er = 1'b0;
        @(posedge sys_clk_i);
        obj_index_o <= idx;
        obj_wdata_o <= wd;
        obj_wr_o <= wr;
        obj_rd_o <= !wr;
        @(posedge sys_clk_i);
        obj_wr_o <= 1'b0;
        obj_rd_o <= 1'b0;
        // Sample on the falling edge so the answer is settled
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge sys_clk_i);
            ok = (obj_ack_i === 1'b1);
            rd = obj_rdata_i;
            er = obj_err_i;
            @(posedge sys_clk_i);
        end
        obj_index_o <= ~idx;
        obj_wdata_o <= ~wd;
    endtask
endmodule

// >>> bench/motion_target_window_monitor_tb.sv
/*
 * Self-checking bench for the motion target window monitor.
 * Assumes obj_master drives the object port; feedback is driven here.
 */
`include "motion_defines.svh"
module motion_target_window_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int T = 10;
    localparam logic [15:0] ridx [6] = '{16'h6068, 16'h606d, 16'h606e,
        16'h606f, 16'h6070, 16'h6071};
    localparam logic [31:0] rval [6] = '{32'h00000064, 32'h0000001e,
        32'h0, 32'h0, 32'h0, 32'h0};
    logic sys_clk_i, rst_i, ack, err, reached, spd_zero, trq_act, wr, rd;
    logic [15:0] idx;
    logic [31:0] wdata, rdata;
    logic signed [31:0] pos_act, pos_tgt, spd_tgt, ramp, spd_act, setp;
    logic signed [15:0] trq;
    logic [31:0] seed = 32'h0000810b;
    int n_fail, checks;

    motion_target_window_monitor #(.TICK_CYCLES(T)) dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .obj_index_i(idx),
        .obj_wr_i(wr), .obj_rd_i(rd), .obj_wdata_i(wdata),
        .obj_rdata_o(rdata), .obj_ack_o(ack), .obj_err_o(err),
        .pos_actual_i(pos_act), .pos_target_i(pos_tgt),
        .speed_target_i(spd_tgt), .ramp_speed_i(ramp),
        .speed_actual_i(spd_act), .target_reached_o(reached),
        .speed_zero_o(spd_zero), .vel_ctrl_setpoint_o(setp),
        .torque_cmd_o(trq), .torque_active_o(trq_act));
    obj_master mst (
        .sys_clk_i(sys_clk_i), .obj_index_o(idx), .obj_wr_o(wr),
        .obj_rd_o(rd), .obj_wdata_o(wdata), .obj_rdata_i(rdata),
        .obj_ack_i(ack), .obj_err_i(err));

    // 250 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    // Xorshift source, fixed start for repeatable runs
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Torque clamped to the smaller of the two maxima
    function automatic logic [15:0] exp_trq(input int t, mt, mc);
        int l;
        l = (mt < mc) ? mt : mc;
        return 16'((t > l) ? l : (t < -l) ? -l : t);
    endfunction

    // Comparison, counts and reports
    task automatic check(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Object access with a missing ack ending the run
    task automatic acc(input logic w, input logic [15:0] i,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        logic ok;
        mst.access(w, i, d, r, e, ok);
        if (!ok) begin
            n_fail++;
            $display("[ERR] ack for %h missing", i);
            wrap_up();
        end
    endtask

    task automatic put(input logic [15:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        acc(1'b1, i, d, r, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic feed(input logic signed [31:0] pa, pt, st, sa);
        @(posedge sys_clk_i);
        pos_act <= pa;
        pos_tgt <= pt;
        spd_tgt <= st;
        spd_act <= sa;
    endtask

    // Main sequence
    initial begin
        logic [31:0] r, v;
        logic [15:0] i;
        logic e;
        int mt, mc, t;
        motion_pkg::op_mode_t m;
        motion_pkg::op_mode_t tm [3];
        tm = '{motion_pkg::MODE_PROFILE_TRQ, motion_pkg::MODE_CYCLIC_TRQ,
            motion_pkg::MODE_PROFILE_VEL};
        n_fail = 0;
        checks = 0;
        rst_i = 1'b1;
        {pos_act, pos_tgt, spd_tgt, ramp, spd_act} = '0;
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        // Preset values
        foreach (ridx[k]) begin
            acc(1'b0, ridx[k], 32'h0, r, e);
            check("preset", r, rval[k]);
            check("preset err", e, 1'b0);
        end
        // Position settling with the preset 100 ms time
        // Start outside the window so counting begins at the feed
        feed(20, 0, 0, 0);
        put(`IDX_OP_MODE, mst.mode_word(motion_pkg::MODE_PROFILE_POS));
        feed(5, 0, 0, 0);
        cyc(100 * T);
        check("pos early", reached, 1'b0);
        cyc(2 * T + 2);
        check("pos reached", reached, 1'b1);
        feed(10, 0, 0, 0);
        cyc(2);
        check("pos edge", reached, 1'b0);
        put(`IDX_POS_SETTLE_TIME, 32'hffff0003);
        feed(-3, 6, 0, 0);
        cyc(3 * T);
        check("pos restart", reached, 1'b0);
        cyc(2 * T + 2);
        check("pos 3 ms", reached, 1'b1);
        put(`IDX_POS_WINDOW, `POS_WINDOW_OFF);
        cyc(5 * T);
        check("pos off", reached, 1'b0);
        put(`IDX_POS_WINDOW, 32'h0000000a);
        put(`IDX_OP_MODE, mst.mode_word(motion_pkg::MODE_INTERP_POS));
        cyc(5 * T + 2);
        check("interp reached", reached, 1'b1);
        // Speed window and nonzero speed
        put(`IDX_OP_MODE, mst.mode_word(motion_pkg::MODE_PROFILE_VEL));
        feed(0, 0, 1000, 1029);
        cyc(2 * T + 2);
        check("vel reached", reached, 1'b1);
        feed(0, 0, 1000, 970);
        cyc(2);
        check("vel band", reached, 1'b0);
        put(`IDX_SPEED_SETTLE_TIME, 32'h2);
        feed(0, 0, 1000, 1000);
        cyc(2 * T);
        check("vel early", reached, 1'b0);
        cyc(2 * T + 2);
        check("vel 2 ms", reached, 1'b1);
        // Drop below the level first so the nonzero timer restarts
        feed(0, 0, 0, 0);
        put(`IDX_NONZERO_SPEED_LEVEL, 32'd100);
        put(`IDX_NONZERO_SPEED_TIME, 32'd2);
        feed(0, 0, 0, -150);
        cyc(T);
        check("nz early", spd_zero, 1'b1);
        cyc(2 * T + 2);
        check("nz moving", spd_zero, 1'b0);
        feed(0, 0, 0, 100);
        cyc(2);
        check("nz level", spd_zero, 1'b1);
        // Read-only speed objects
        @(posedge sys_clk_i);
        ramp <= rnd();
        spd_act <= rnd();
        cyc(2);
        check("setpoint", setp, ramp);
        acc(1'b0, `IDX_SPEED_SETPOINT_OUT, 32'h0, r, e);
        check("606b", r, ramp);
        acc(1'b0, `IDX_SPEED_MEASURED, 32'h0, r, e);
        check("606c", r, spd_act);
        acc(1'b1, `IDX_SPEED_SETPOINT_OUT, rnd(), r, e);
        check("606b write", e, 1'b1);
        acc(1'b1, `IDX_SPEED_MEASURED, rnd(), r, e);
        check("606c write", e, 1'b1);
        // Random write and read back
        for (int k = 0; k < 12; k++) begin
            v = rnd();
            i = ridx[k % 6];
            put(i, v);
            acc(1'b0, i, 32'h0, r, e);
            check("object", r, (i == 16'h6071) ? {{16{v[15]}}, v[15:0]}
                : {16'h0000, v[15:0]});
        end
        // Torque limit and mode gating
        for (int k = 0; k < 9; k++) begin
            mt = (k == 0) ? 1000 : int'(rnd() % 1000);
            mc = (k == 0) ? 600 : int'(rnd() % 1000);
            t = (k == 0) ? 500 : int'(rnd() % 3000) - 1500;
            m = tm[k % 3];
            put(`IDX_TORQUE_MAX, 32'(mt));
            put(`IDX_CURRENT_MAX, 32'(mc));
            put(`IDX_TORQUE_SETPOINT_IN, mst.torque_word(t));
            put(`IDX_OP_MODE, mst.mode_word(m));
            cyc(2);
            check("trq on", trq_act, m != tm[2]);
            check("trq", {16'h0000, trq}, (m == tm[2]) ? 32'h0
                : {16'h0000, exp_trq(t, mt, mc)});
        end
        wrap_up();
    end
endmodule
